// ---- level_sync2.sv ----
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/1ps

module level_sync2
(
  input  wire logic mclk_i,
  input  wire logic arst_n_i,
  input  wire logic async_i,
  output logic      sync_o
);

  logic meta;

  // The first stage feeds only the second stage
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      meta   <= 1'b0;
      sync_o <= 1'b0;
    end
    else
    begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule : level_sync2

// ---- supply_level_monitor.sv ----
// APB register block of the supply level monitor
`timescale 1ns/1ps

// What this block does
// - Low four bits select one of four thresholds
// - Threshold select resets to lowest threshold code
// - Enable bit switches comparator on, resets off
// - Result flag is read-only, writes ignored
// - Flag reads one when supply below threshold
// - Result flag resets to zero
// - Byte access, plus word access pairing both
module supply_level_monitor
#(
  parameter int SETTLE_CYCLES = supply_level_monitor_pkg::SETTLE_CYCLES
)
(
  input  wire logic        mclk_i,
  input  wire logic        arst_n_i,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cmp_below_i,
  output logic             monitor_enable_o,
  output logic      [3:0]  threshold_sel_o,
  output logic             settled_o,
  output logic             irq_o
);

  logic [7:0]                            threshold_reg;
  supply_level_monitor_pkg::enres_t      enres;
  supply_level_monitor_pkg::evt_t        irq_stat;
  supply_level_monitor_pkg::evt_t        irq_en;
  supply_level_monitor_pkg::evt_t        evt;
  logic                                  cmp_sync;
  logic [supply_level_monitor_pkg::CNT_W-1:0] settle_cnt;
  logic                                  settled;
  logic                                  setup_ph;
  logic                                  wr_acc;
  logic                                  hit_thresh;
  logic                                  hit_enres;
  logic                                  hit_stat;
  logic                                  hit_clr;
  logic                                  hit_en;
  logic                                  mapped;
  logic                                  wr_sel;
  logic                                  wr_enable;
  logic                                  wr_enres_hi;
  logic                                  new_enable;
  logic                                  new_code_ok;
  logic [31:0]                           next_prdata;
  logic [supply_level_monitor_pkg::CNT_W-1:0] settle_last;
  logic                                  monitor_enable;
  logic                                  below_threshold_flag;
  logic [5:0]                            spare_bits;

  assign settle_last = supply_level_monitor_pkg::CNT_W'(SETTLE_CYCLES - 1);

  // Each field has its own flop so that only one process drives it
  assign enres = {spare_bits, below_threshold_flag, monitor_enable};

  // Comparator output is analog-side and asynchronous to mclk_i
  level_sync2 u_cmp_sync
  (
    .mclk_i   (mclk_i),
    .arst_n_i (arst_n_i),
    .async_i  (cmp_below_i),
    .sync_o   (cmp_sync)
  );

  // Address decode
  always_comb
  begin
    hit_thresh = 1'b0;
    hit_enres  = 1'b0;
    hit_stat   = 1'b0;
    hit_clr    = 1'b0;
    hit_en     = 1'b0;
    if (paddr == supply_level_monitor_pkg::ADDR_THRESH)
      hit_thresh = 1'b1;
    else if (paddr == supply_level_monitor_pkg::ADDR_ENRES)
      hit_enres = 1'b1;
    else if (paddr == supply_level_monitor_pkg::ADDR_IRQ_STAT)
      hit_stat = 1'b1;
    else if (paddr == supply_level_monitor_pkg::ADDR_IRQ_CLR)
      hit_clr = 1'b1;
    else if (paddr == supply_level_monitor_pkg::ADDR_IRQ_EN)
      hit_en = 1'b1;
  end

  assign mapped   = hit_thresh | hit_enres | hit_stat | hit_clr | hit_en;
  assign setup_ph = psel & ~penable;
  assign wr_acc   = psel & penable & pwrite & mapped;

  // Lane 0 at the threshold word is the byte view; lane 1 there is the
  // high byte of the word view, which lands in the enable/result byte.
  assign wr_sel      = wr_acc & hit_thresh & pstrb[0];
  assign wr_enable   = wr_acc & ((hit_thresh & pstrb[1]) | (hit_enres & pstrb[0]));
  assign new_enable  = hit_thresh ? pwdata[8 + supply_level_monitor_pkg::ENABLE_BIT]
                                  : pwdata[supply_level_monitor_pkg::ENABLE_BIT];
  assign wr_enres_hi = wr_enable;

  // Zero wait states: read data is latched in the setup phase
  assign pready = 1'b1;

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      threshold_reg <= supply_level_monitor_pkg::RST_THRESH;
    else if (wr_sel)
      threshold_reg <= pwdata[7:0];
  end

  assign threshold_sel_o = threshold_reg[supply_level_monitor_pkg::SEL_LSB +: supply_level_monitor_pkg::SEL_W];

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      monitor_enable <= 1'b0;
      spare_bits     <= 6'h00;
    end
    else if (wr_enres_hi)
    begin
      monitor_enable <= new_enable;
      spare_bits     <= hit_thresh ? pwdata[15:10] : pwdata[7:2];
    end
  end

  assign monitor_enable_o = enres.enable;

  // The flag holds its last comparison while the monitor is off, so a
  // reading taken just before disabling stays visible. Bus writes never
  // reach it.
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      below_threshold_flag <= 1'b0;
    else if (enres.enable)
      below_threshold_flag <= cmp_sync;
  end

  // Settling timer; restarts every time the monitor is switched on
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      settle_cnt <= '0;
      settled    <= 1'b0;
    end
    else if (!enres.enable)
    begin
      settle_cnt <= '0;
      settled    <= 1'b0;
    end
    else if (!settled)
    begin
      if (settle_cnt == settle_last)
        settled <= 1'b1;
      else
        settle_cnt <= settle_cnt + 1'b1;
    end
  end

  assign settled_o = settled;

  // Catches software that breaks the code or the change-while-off policy
  always_comb
  begin
    new_code_ok = 1'b0;
    case (pwdata[3:0])
      supply_level_monitor_pkg::THR_2V35: new_code_ok = 1'b1;
      supply_level_monitor_pkg::THR_2V80: new_code_ok = 1'b1;
      supply_level_monitor_pkg::THR_3V70: new_code_ok = 1'b1;
      supply_level_monitor_pkg::THR_4V60: new_code_ok = 1'b1;
      default:                            new_code_ok = 1'b0;
    endcase
  end

  always_comb
  begin
    evt              = supply_level_monitor_pkg::RST_EVT;
    evt.settled      = enres.enable & ~settled & (settle_cnt == settle_last);
    evt.went_below   = enres.enable & settled & cmp_sync & ~enres.flag;
    evt.bad_code     = wr_sel & ~new_code_ok;
    evt.sel_while_on = wr_sel & enres.enable;
  end

  // Set wins over a clear arriving in the same cycle
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      irq_stat <= supply_level_monitor_pkg::RST_EVT;
    else if (wr_acc & hit_clr & pstrb[0])
      irq_stat <= (irq_stat & ~pwdata[3:0]) | evt;
    else
      irq_stat <= irq_stat | evt;
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      irq_en <= supply_level_monitor_pkg::RST_EVT;
    else if (wr_acc & hit_en & pstrb[0])
      irq_en <= pwdata[3:0];
  end

  assign irq_o = |(irq_stat & irq_en);

  always_comb
  begin
    next_prdata = 32'h0000_0000;
    if (hit_thresh)
      next_prdata = {16'h0000, enres, threshold_reg};
    else if (hit_enres)
      next_prdata = {24'h00_0000, enres};
    else if (hit_stat)
      next_prdata = {28'h000_0000, irq_stat};
    else if (hit_en)
      next_prdata = {28'h000_0000, irq_en};
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (setup_ph)
    begin
      prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= ~mapped;
    end
  end

  // Helper: low only in the first cycle after reset release
  logic seen_clk;

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      seen_clk <= 1'b0;
    else
      seen_clk <= 1'b1;
  end

  a_sel_written: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    wr_sel |=> threshold_sel_o == $past(pwdata[3:0]))
    else $error("threshold select did not take the written code");

  a_sel_reset: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    !seen_clk |-> threshold_reg == 8'h00 && threshold_sel_o == 4'h0)
    else $error("threshold select not zero after reset");

  a_enable_written: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    wr_enable |=> monitor_enable_o == $past(new_enable))
    else $error("enable bit did not take the written value");

  a_flag_readonly: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    !monitor_enable_o |=> $stable(enres.flag))
    else $error("result flag moved while monitor off");

  a_flag_follows: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    monitor_enable_o |=> enres.flag == $past(cmp_sync))
    else $error("result flag does not follow comparison");

  a_flag_reset: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    !seen_clk |-> !enres.flag && !monitor_enable_o)
    else $error("result flag or enable not zero after reset");

  a_word_view: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    setup_ph && !pwrite && hit_thresh |=> prdata[15:8] == $past(enres)
      && prdata[7:0] == $past(threshold_reg))
    else $error("word read does not pair the two control bytes");

  a_sync_depth: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    $rose(enres.flag) |-> $past(cmp_below_i, 3))
    else $error("flag rose without a comparator level three cycles back");

  a_flag_bus_proof: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    wr_acc && (hit_thresh || hit_enres) && !enres.enable |=> $stable(enres.flag))
    else $error("bus write moved the result flag");

  a_settle_time: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    $rose(settled) |-> settle_cnt == settle_last)
    else $error("settled rose before the full settling count");

  a_settle_drop: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    !monitor_enable_o |=> !settled_o)
    else $error("settled stayed high with the monitor off");

  a_settle_reset: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    !seen_clk |-> !settled_o && !irq_o)
    else $error("settled or interrupt not zero after reset");

  a_unmapped_err: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    setup_ph && !mapped |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not answered with an error");

  a_no_stray_write: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    wr_acc && !hit_thresh |=> $stable(threshold_sel_o))
    else $error("threshold select changed by a write elsewhere");

  a_bad_code_seen: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    wr_sel && !new_code_ok |=> irq_stat.bad_code)
    else $error("prohibited code write not recorded");

  a_set_beats_clear: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    wr_acc && hit_clr && pstrb[0] && evt.went_below |=> irq_stat.went_below)
    else $error("clear overrode an event in the same cycle");

  c_word_write: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
    wr_sel && wr_enable);

  c_settled_below: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
    settled && $rose(enres.flag));

  c_irq_raised: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
    $rose(irq_o));

  c_bad_code: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
    $rose(irq_stat.bad_code));

  c_flag_held: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
    $fell(monitor_enable_o) && enres.flag);

endmodule : supply_level_monitor

// ---- supply_level_monitor_pkg.sv ----
// Constants, register map and carrier types of the supply level monitor
package supply_level_monitor_pkg;

  // Register indices; each index is one 32-bit word, byte address = index * 4
  localparam logic [15:0] IDX_THRESH   = 16'hf0d0;
  localparam logic [15:0] IDX_ENRES    = 16'hf0d1;
  localparam logic [15:0] IDX_IRQ_STAT = 16'hf0d2;
  localparam logic [15:0] IDX_IRQ_CLR  = 16'hf0d3;
  localparam logic [15:0] IDX_IRQ_EN   = 16'hf0d4;

  localparam logic [31:0] ADDR_THRESH   = {14'h0000, IDX_THRESH, 2'b00};
  localparam logic [31:0] ADDR_ENRES    = {14'h0000, IDX_ENRES, 2'b00};
  localparam logic [31:0] ADDR_IRQ_STAT = {14'h0000, IDX_IRQ_STAT, 2'b00};
  localparam logic [31:0] ADDR_IRQ_CLR  = {14'h0000, IDX_IRQ_CLR, 2'b00};
  localparam logic [31:0] ADDR_IRQ_EN   = {14'h0000, IDX_IRQ_EN, 2'b00};

  // Legal threshold select codes
  localparam logic [3:0] THR_2V35 = 4'h0;
  localparam logic [3:0] THR_2V80 = 4'h3;
  localparam logic [3:0] THR_3V70 = 4'h9;
  localparam logic [3:0] THR_4V60 = 4'hf;

  localparam logic [7:0] RST_THRESH = 8'h00;
  localparam logic [7:0] RST_ENRES  = 8'h00;
  localparam logic [3:0] RST_EVT    = 4'h0;

  localparam int ENABLE_BIT = 0;
  localparam int FLAG_BIT   = 1;
  localparam int SEL_LSB    = 0;
  localparam int SEL_W      = 4;

  // Settling time after enable, least time, rounded up to whole cycles
  localparam int SETTLE_NS     = 1000000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 18;

  typedef struct packed {
    logic sel_while_on;
    logic bad_code;
    logic went_below;
    logic settled;
  } evt_t;

  typedef struct packed {
    logic [5:0] spare;
    logic       flag;
    logic       enable;
  } enres_t;

endpackage : supply_level_monitor_pkg

// ---- test_supply_level_monitor.sv ----
// Self-checking random testbench of the supply level monitor registers
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
    end \
  end

module test_supply_level_monitor;
  localparam int          SETTLE = 20;
  localparam logic [31:0] A_THR  = supply_level_monitor_pkg::ADDR_THRESH;
  localparam logic [31:0] A_ENR  = supply_level_monitor_pkg::ADDR_ENRES;
  localparam logic [31:0] A_STA  = supply_level_monitor_pkg::ADDR_IRQ_STAT;
  localparam logic [31:0] A_CLR  = supply_level_monitor_pkg::ADDR_IRQ_CLR;
  localparam logic [31:0] A_IEN  = supply_level_monitor_pkg::ADDR_IRQ_EN;
  logic        mclk_i, arst_n_i, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0]  pstrb, threshold_sel_o, c;
  logic        cmp_below_i, monitor_enable_o, settled_o, irq_o, err;
  logic [7:0]  thr, enres, e;
  logic [3:0]  codes [4] = '{4'h0, 4'h3, 4'h9, 4'hf};
  int          mismatches, total_checks, cycles, n;

  supply_level_monitor #(.SETTLE_CYCLES(SETTLE)) u_supply_level_monitor (.*);

  initial
  begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  function automatic logic [31:0] word_of(input logic [7:0] t, input logic [7:0] r);
    return {16'h0000, r, t};
  endfunction : word_of

  function automatic logic legal(input logic [3:0] k);
    return k inside {4'h0, 4'h3, 4'h9, 4'hf};
  endfunction : legal

  // Request held until pready is seen high; read data taken at that edge only
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int w;
    w = 0;
    @(posedge mclk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge mclk_i);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk_i);
      w++;
    end while (pready !== 1'b1 && w < 50);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  // Whole run needs under two hundred cycles; the ceiling leaves wide margin
  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      conclude();
    end
  end

  initial
  begin
    {arst_n_i, psel, penable, pwrite, cmp_below_i} = 5'h00;
    {paddr, pwdata, pstrb} = '0;
    {mismatches, total_checks, cycles} = '0;
    enres = 8'h00;
    repeat (8) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    void'($urandom(49));
    apb(1'b0, A_THR, 32'h0, 4'h0);
    `CHK(rd, 32'h0)
    `CHK({monitor_enable_o, threshold_sel_o, settled_o, irq_o}, 7'h00)
    $display("test reset done");
    foreach (codes[i])
    begin
      thr = {4'($urandom), codes[i]};
      apb(1'b1, A_THR, {24'h0, thr}, 4'h1);
      @(negedge mclk_i);
      `CHK(threshold_sel_o, codes[i])
      apb(1'b0, A_THR, 32'h0, 4'h0);
      `CHK(rd, word_of(thr, enres))
    end
    apb(1'b0, A_STA, 32'h0, 4'h0);
    `CHK(rd, 32'h0)
    $display("test codes done");
    do c = 4'($urandom); while (legal(c));
    apb(1'b1, A_IEN, 32'h4, 4'h1);
    apb(1'b1, A_THR, {28'h0, c}, 4'h1);
    @(negedge mclk_i);
    `CHK({threshold_sel_o, irq_o}, {c, 1'b1})
    apb(1'b1, A_IEN, 32'h0, 4'h1);
    @(negedge mclk_i);
    `CHK(irq_o, 1'b0)
    apb(1'b0, A_STA, 32'h0, 4'h0);
    `CHK(rd, 32'h4)
    apb(1'b1, A_CLR, 32'h4, 4'h1);
    apb(1'b0, A_STA, 32'h0, 4'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, A_CLR, 32'h0, 4'h0);
    `CHK(rd, 32'h0)
    $display("test interrupt done");
    apb(1'b1, A_THR, 32'h9, 4'h1);
    e = {6'($urandom), 2'b11};
    apb(1'b1, A_ENR, {24'h0, e}, 4'h1);
    enres = {e[7:2], 2'b01};
    @(negedge mclk_i);
    `CHK(monitor_enable_o, 1'b1)
    apb(1'b0, A_ENR, 32'h0, 4'h0);
    `CHK(rd, {24'h0, enres})
    n = 0;
    while (settled_o !== 1'b1 && n < SETTLE + 20)
    begin
      @(posedge mclk_i);
      n++;
    end
    `CHK(settled_o, 1'b1)
    @(posedge mclk_i);
    cmp_below_i <= 1'b1;
    // Read launched at once must still see the old flag behind the synchroniser
    apb(1'b0, A_ENR, 32'h0, 4'h0);
    `CHK(rd[1], 1'b0)
    enres[1] = 1'b1;
    apb(1'b0, A_ENR, 32'h0, 4'h0);
    `CHK(rd, {24'h0, enres})
    apb(1'b0, A_STA, 32'h0, 4'h0);
    `CHK(rd, 32'h3)
    cmp_below_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    enres[1] = 1'b0;
    apb(1'b0, A_ENR, 32'h0, 4'h0);
    `CHK(rd, {24'h0, enres})
    apb(1'b1, A_THR, 32'hf, 4'h1);
    apb(1'b0, A_STA, 32'h0, 4'h0);
    `CHK(rd[3:1], 3'b101)
    cmp_below_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    apb(1'b1, A_ENR, {24'h0, e[7:2], 2'b00}, 4'h1);
    enres = {e[7:2], 2'b10};
    cmp_below_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    `CHK({monitor_enable_o, settled_o}, 2'b00)
    apb(1'b0, A_ENR, 32'h0, 4'h0);
    `CHK(rd, {24'h0, enres})
    $display("test measure done");
    apb(1'b1, A_THR, 32'h0103, 4'h3);
    @(negedge mclk_i);
    `CHK({monitor_enable_o, threshold_sel_o}, 5'h13)
    enres = 8'h01;
    apb(1'b0, A_THR, 32'h0, 4'h0);
    `CHK(rd, word_of(8'h03, enres))
    apb(1'b0, A_ENR, 32'h0, 4'h0);
    `CHK(rd, {24'h0, enres})
    apb(1'b1, A_IEN + 32'h4, 32'hffffffff, 4'hf);
    `CHK(err, 1'b1)
    apb(1'b0, A_IEN + 32'h4, 32'h0, 4'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    $display("test word done");
    conclude();
  end
endmodule : test_supply_level_monitor
